// [shared/snc_pkg.sv]
// constants and types for the stack, negate and call execution slice
// assumes one core clock split into four phases per instruction cycle
package snc_pkg;
  localparam int PC_W = 21;
  localparam int STK_DEPTH = 31;
  localparam int SP_W = 5;
  // opcode patterns and masks
  localparam logic [15:0] OP_NEG_MASK = 16'hfe00;
  localparam logic [15:0] OP_NEG_VAL = 16'h6c00;
  localparam logic [15:0] OP_POP = 16'h0006;
  localparam logic [15:0] OP_PUSH = 16'h0005;
  localparam logic [15:0] OP_RESET = 16'h00ff;
  localparam logic [15:0] OP_NOP = 16'h0000;
  localparam logic [15:0] OP_CALL_MASK = 16'hf800;
  localparam logic [15:0] OP_CALL_VAL = 16'hd800;
  localparam int ABIT_POS = 8;
  // access bank split and upper bank
  localparam logic [7:0] ACC_SPLIT = 8'h80;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  // flag positions in the status byte
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z = 2;
  localparam int FL_OV = 3;
  localparam int FL_N = 4;
  // register port offsets
  localparam logic [7:0] REG_BANK = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TOP = 8'h08;
  localparam logic [7:0] REG_DEPTH = 8'h0c;
  localparam logic [7:0] REG_PC = 8'h10;
  // reset values, the pc step per instruction and the phase type
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} snc_phase_t;
endpackage

// [logic/snc_ret_stack.sv]
// return stack: push moves the old top one level down, pop drops the top
// assumes push and pop never arrive in the same cycle
`timescale 1ns/1ps
module snc_ret_stack (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  input wire logic push,
  input wire logic pop,
  input wire logic [snc_pkg::PC_W-1:0] push_data,
  output logic [snc_pkg::PC_W-1:0] top,
  output logic [snc_pkg::SP_W-1:0] depth
);
  import snc_pkg::*;
  typedef struct packed {
    logic [STK_DEPTH-1:0][PC_W-1:0] ent;
    logic [SP_W-1:0] sp;
  } snc_stk_t;
  snc_stk_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.sp = '0;
    end else if (push) begin
      // a full stack drops the push rather than overwrite old returns
      if (s_q.sp < SP_W'(STK_DEPTH)) begin
        s_d.ent[s_q.sp] = push_data;
        s_d.sp = s_q.sp + 5'h01;
      end
    end else if (pop) begin
      if (s_q.sp != '0) begin
        s_d.sp = s_q.sp - 5'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign top = (s_q.sp == '0) ? '0 : s_q.ent[s_q.sp - 5'h01];
  assign depth = s_q.sp;
endmodule

// [logic/snc_negate.sv]
// two's complement negate of one byte with its flag results
// purely combinational; the caller registers both outputs
`timescale 1ns/1ps
module snc_negate (
  input wire logic [7:0] opnd,
  output logic [7:0] res,
  output logic [4:0] flags
);
  import snc_pkg::*;
  always_comb begin
    res = (~opnd) + 8'h01;
    flags = '0;
    flags[FL_N] = res[7];
    flags[FL_Z] = (res == 8'h00);
    // 0 - f: carry means no borrow, only when f is zero
    flags[FL_C] = (opnd == 8'h00);
    flags[FL_DC] = (opnd[3:0] == 4'h0);
    flags[FL_OV] = (opnd == 8'h80);
  end
endmodule

// [logic/snc_core.sv]
// execution slice: negate file byte, stack pop and push, relative call,
// no-operation and software reset, one instruction per four mclk phases
// assumes the fetch side holds instr_word valid in phase Q1 for fetch_addr,
// data memory answers a read in the next cycle, and the register port
// master follows the one-cycle strobe protocol
`timescale 1ns/1ps
module snc_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] instr_word,
  output logic [snc_pkg::PC_W-1:0] fetch_addr,
  output snc_pkg::snc_phase_t phase,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic soft_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import snc_pkg::*;

  typedef struct packed {
    snc_phase_t ph;
    logic [15:0] ir;
    logic flush;
    logic [PC_W-1:0] pc;
    logic [3:0] bank_select_reg;
    logic [4:0] flags;
    logic [11:0] maddr;
    logic [7:0] wdata;
    logic [31:0] rdata;
  } snc_core_t;

  localparam snc_core_t CORE_RST = '{
    ph: PH_Q1,
    ir: OP_NOP,
    flush: 1'b0,
    pc: PC_RST,
    bank_select_reg: BANK_RST,
    flags: STATUS_RST,
    maddr: 12'h000,
    wdata: 8'h00,
    rdata: 32'h00000000
  };

  snc_core_t c_q, c_d;
  logic is_neg, is_pop, is_push, is_call, is_sreset;
  logic [PC_W-1:0] ret_addr, call_target, stack_top;
  logic [SP_W-1:0] stack_depth;
  logic stk_push, stk_pop;
  logic [7:0] neg_res;
  logic [4:0] neg_flags;

  // file address from the access bit, the bank register and the offset
  function automatic logic [11:0] file_addr(
    input logic [15:0] word,
    input logic [3:0] bank
  );
    logic [7:0] f;
    f = word[7:0];
    if (word[ABIT_POS]) begin
      file_addr = {bank, f};
    end else if (f < ACC_SPLIT) begin
      file_addr = {ACC_LO_BANK, f};
    end else begin
      file_addr = {ACC_HI_BANK, f};
    end
  endfunction

  function automatic logic opcode_is(
    input logic [15:0] word,
    input logic [15:0] mask,
    input logic [15:0] val
  );
    opcode_is = ((word & mask) == val);
  endfunction

  // decode of the word held for this instruction cycle; anything else,
  // including the zero word and the 1111 group, falls through as no-op
  always_comb begin
    is_neg = opcode_is(c_q.ir, OP_NEG_MASK, OP_NEG_VAL);
    is_pop = (c_q.ir == OP_POP);
    is_push = (c_q.ir == OP_PUSH);
    is_call = opcode_is(c_q.ir, OP_CALL_MASK, OP_CALL_VAL);
    is_sreset = (c_q.ir == OP_RESET);
  end

  always_comb begin
    ret_addr = c_q.pc + PC_STEP;
    // word offset doubled to bytes, sign carried across the full pc width
    call_target = ret_addr +
      {{(PC_W-12){c_q.ir[10]}}, c_q.ir[10:0], 1'b0};
  end

  // stack moves are issued from the held word in their own phase
  assign stk_push = (c_q.ph == PH_Q2) && (is_push || is_call);
  assign stk_pop = (c_q.ph == PH_Q3) && is_pop;
  assign soft_rst = (c_q.ph == PH_Q2) && is_sreset;

  snc_ret_stack u_stack (
    .mclk(mclk),
    .rst(rst),
    .clr(soft_rst),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(ret_addr),
    .top(stack_top),
    .depth(stack_depth)
  );

  snc_negate u_neg (
    .opnd(mem_rdata),
    .res(neg_res),
    .flags(neg_flags)
  );

  always_comb begin
    c_d = c_q;
    // register port writes; hardware flag updates below take priority
    if (reg_wr) begin
      if (reg_addr == REG_BANK) begin
        c_d.bank_select_reg = reg_wdata[3:0];
      end else if (reg_addr == REG_STATUS) begin
        c_d.flags = reg_wdata[4:0];
      end
    end
    // register port reads, data stand in the next cycle only
    c_d.rdata = 32'h00000000;
    if (reg_rd) begin
      if (reg_addr == REG_BANK) begin
        c_d.rdata = {28'h0000000, c_q.bank_select_reg};
      end else if (reg_addr == REG_STATUS) begin
        c_d.rdata = {27'h0000000, c_q.flags};
      end else if (reg_addr == REG_TOP) begin
        c_d.rdata = {11'h000, stack_top};
      end else if (reg_addr == REG_DEPTH) begin
        c_d.rdata = {27'h0000000, stack_depth};
      end else if (reg_addr == REG_PC) begin
        c_d.rdata = {11'h000, c_q.pc};
      end
    end
    case (c_q.ph)
      PH_Q1: begin
        c_d.ph = PH_Q2;
        // the refetch cycle after a call discards its word
        c_d.ir = c_q.flush ? OP_NOP : instr_word;
        c_d.maddr = file_addr(instr_word, c_q.bank_select_reg);
      end
      PH_Q2: begin
        c_d.ph = PH_Q3;
      end
      PH_Q3: begin
        c_d.ph = PH_Q4;
        if (is_neg) begin
          c_d.wdata = neg_res;
          c_d.flags = neg_flags;
        end
      end
      PH_Q4: begin
        c_d.ph = PH_Q1;
        if (is_call) begin
          c_d.pc = call_target;
          c_d.flush = 1'b1;
        end else if (!c_q.flush) begin
          c_d.pc = ret_addr;
        end else begin
          // flush lives through the whole refetch cycle so pc holds there
          c_d.flush = 1'b0;
        end
      end
      default: begin
        c_d.ph = PH_Q1;
      end
    endcase
    // a software reset overrides everything from its second phase on
    if (soft_rst) begin
      c_d = CORE_RST;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      c_q <= CORE_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // read in Q2, data back in Q3, same address written in Q4
  assign mem_rd = (c_q.ph == PH_Q2) && is_neg;
  assign mem_wr = (c_q.ph == PH_Q4) && is_neg;
  assign mem_addr = c_q.maddr;
  assign mem_wdata = c_q.wdata;
  assign fetch_addr = c_q.pc;
  assign phase = c_q.ph;
  assign reg_rdata = c_q.rdata;
endmodule

// [verif/snc_core_props.sv]
// checker for snc_core: phase walk, negate cycle, bank choice, reset
// sees only core ports; bound to every snc_core
`timescale 1ns/1ps
module snc_core_props (
  input logic mclk,
  input logic rst,
  input logic [15:0] instr_word,
  input logic [snc_pkg::PC_W-1:0] fetch_addr,
  input snc_pkg::snc_phase_t phase,
  input logic [11:0] mem_addr,
  input logic mem_rd,
  input logic [7:0] mem_rdata,
  input logic mem_wr,
  input logic [7:0] mem_wdata,
  input logic soft_rst
);
  import snc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_neg_tail;
    !mem_wr ##1 mem_wr;
  endsequence
  sequence s_wrap;
    phase == PH_Q4 ##1 phase == PH_Q1;
  endsequence
  a_rd_to_wr: assert property (mem_rd |=> s_neg_tail)
    else $error("negate write missing");
  a_wr_addr: assert property (mem_wr |-> mem_addr == $past(mem_addr, 2))
    else $error("negate write address moved");
  a_neg_val: assert property (mem_wr |-> mem_wdata == 8'h00 - $past(mem_rdata))
    else $error("negate value wrong");
  a_rd_phase: assert property (mem_rd |-> phase == PH_Q2)
    else $error("read outside Q2");
  a_acc_bank: assert property (phase == PH_Q1 && !instr_word[ABIT_POS]
    && (instr_word & OP_NEG_MASK) == OP_NEG_VAL |=> mem_addr ==
    {($past(instr_word[7]) ? ACC_HI_BANK : ACC_LO_BANK), $past(instr_word[7:0])})
    else $error("access bank address wrong");
  a_nop_quiet: assert property (phase == PH_Q1 && instr_word[15:12] == 4'hf
    |=> (!mem_rd && !mem_wr && !soft_rst) [*3])
    else $error("no-op touched memory");
  a_soft_q2: assert property (soft_rst |-> phase == PH_Q2 ##1
    (phase == PH_Q1 && fetch_addr == PC_RST))
    else $error("soft reset incomplete");
  a_pc_moves: assert property ($changed(fetch_addr) |->
    $past(phase) == PH_Q4 || $past(soft_rst))
    else $error("pc moved mid cycle");
  a_q3_walk: assert property (phase == PH_Q3 |=> s_wrap)
    else $error("phase walk broken");
endmodule
bind snc_core snc_core_props u_props (.mclk, .rst, .instr_word, .fetch_addr,
  .phase, .mem_addr, .mem_rd, .mem_rdata, .mem_wr, .mem_wdata, .soft_rst);

// [verif/snc_mem_model.sv]
// program store and data memory on the far side of snc_core
// contents are preloaded by the bench through hierarchy
`timescale 1ns/1ps
module snc_mem_model (
  input logic mclk,
  input logic [snc_pkg::PC_W-1:0] fetch_addr,
  output logic [15:0] instr_word,
  input logic [11:0] mem_addr,
  input logic mem_rd,
  output logic [7:0] mem_rdata,
  input logic mem_wr,
  input logic [7:0] mem_wdata
);
  import snc_pkg::*;
  logic [15:0] prog [0:31];
  logic [7:0] dmem [0:4095];
  assign instr_word = prog[fetch_addr[5:1]];
  initial mem_rdata = 8'h5a;
  // junk outside the answer cycle so a late sample cannot pass by luck
  always @(posedge mclk) begin
    mem_rdata <= mem_rd ? dmem[mem_addr] : ~mem_rdata;
    if (mem_wr) begin
      dmem[mem_addr] <= mem_wdata;
    end
  end
endmodule

// [verif/stack_negate_call_exec_tb_top.sv]
// bench for snc_core: runs a preloaded program, checks memory and registers
// assumes snc_mem_model as far side and the bound checker
`timescale 1ns/1ps
module stack_negate_call_exec_tb_top;
  import snc_pkg::*;
  logic mclk, rst, reg_wr, reg_rd, mem_rd, mem_wr, soft_rst;
  logic [15:0] instr_word;
  logic [PC_W-1:0] fetch_addr;
  snc_phase_t phase;
  logic [11:0] mem_addr;
  logic [7:0] mem_rdata, mem_wdata, reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int errors, cmp_count, cyc, t0;
  snc_core dut (.mclk, .rst, .instr_word, .fetch_addr, .phase, .mem_addr,
    .mem_rd, .mem_rdata, .mem_wr, .mem_wdata, .soft_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  snc_mem_model u_mem (.mclk, .fetch_addr, .instr_word, .mem_addr, .mem_rd,
    .mem_rdata, .mem_wr, .mem_wdata);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // the whole program needs about 60 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic wait_pc(input logic [PC_W-1:0] a);
    int n;
    n = 0;
    while (fetch_addr !== a && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 40) begin
      chk(fetch_addr, a);
    end
  endtask
  task automatic t_negate();
    wait_pc(21'h4);
    reg_check(REG_STATUS, 32'h10);
    chk(u_mem.dmem[12'h010], 32'hc6);
    wait_pc(21'h6);
    reg_check(REG_STATUS, 32'h1a);
    chk(u_mem.dmem[12'h320], 32'h80);
    wait_pc(21'h8);
    reg_check(REG_STATUS, 32'h07);
    chk(u_mem.dmem[12'hf90], 32'h00);
  endtask
  task automatic t_stack_call();
    wait_pc(21'ha);
    t0 = cyc;
    wait_pc(21'h12);
    chk(cyc - t0, 4);
    reg_check(REG_TOP, 32'hc);
    reg_check(REG_DEPTH, 32'h2);
    wait_pc(21'h14);
    chk(cyc - t0, 12);
    reg_check(REG_STATUS, 32'h07);
    reg_check(REG_TOP, 32'ha);
  endtask
  task automatic t_reset();
    wait_pc(21'h0);
    reg_check(REG_BANK, 32'h0);
    reg_check(REG_DEPTH, 32'h0);
    reg_check(REG_STATUS, 32'h0);
    reg_check(8'h40, 32'h0);
  endtask
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    for (int i = 0; i < 32; i++) begin
      u_mem.prog[i] = 16'h0000;
    end
    u_mem.prog[1] = 16'h6c10;
    u_mem.prog[2] = 16'h6d20;
    u_mem.prog[3] = 16'h6c90;
    u_mem.prog[4] = 16'h0005;
    u_mem.prog[5] = 16'hd803;
    u_mem.prog[9] = 16'h0006;
    u_mem.prog[10] = 16'hf123;
    u_mem.prog[11] = 16'h00ff;
    u_mem.dmem[12'h010] = 8'h3a;
    u_mem.dmem[12'h320] = 8'h80;
    u_mem.dmem[12'hf90] = 8'h00;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    reg_addr <= REG_BANK;
    reg_wdata <= 32'h3;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    t_negate();
    t_stack_call();
    t_reset();
    print_verdict();
  end
endmodule
